// ===== include/pci_ctrl_cfg_status_regs.svh
// register offsets, field positions and reset values for the pci controller config/status bank
// How it works
// - initiator accesses to pci i/o space are allowed only while initiator_io_space_enable is 1, which resets to 0.
// - a pci target access is accepted only when target_access_ready and cfg_load_complete are both 1.
// - while target_access_ready is 0 every configuration access to this device gets a retry.
// - target_access_ready resets to 1 only in pci boot mode together with satellite mode, else 0.
// - initiator configuration cycles through the cycle address/data registers run only while initiator_cfg_access_enable is 1, which resets to 1.
// - a soft reset loads configuration space from the four data registers when cfg_load_source_select is 1, else from the eeprom.
// - in host mode a pme assertion sets status bit 10, which resets to 0 and clears on a written 1.
// - a dma burst longer than 8 dwords sets status bit 9, cleared by a written 1.
// - a dma burst with decrementing addresses sets status bit 8, cleared by a written 1.
// - a dma burst with no address increment sets status bit 7, cleared by a written 1.
// - any perr assertion on the bus sets status bit 5 even when idle, cleared by a written 1.
// - any serr assertion on the bus sets status bit 4 even when idle, cleared by a written 1.
// - only an internal-bus timeout ending a cycle mastered by this controller sets status bit 3, cleared by a written 1.
// - initiator_write_busy reads 1 while a posted write is in flight and that write's error is withheld until it drops.
// - cfg_load_complete (bit 0) goes to 1 when the internal load sequence ends, even with no eeprom.
`ifndef PCI_CTRL_CFG_STATUS_REGS_SVH
`define PCI_CTRL_CFG_STATUS_REGS_SVH

`define OFS_CONFIG     16'hD170
`define OFS_STATUS     16'hD174
`define OFS_MASK       16'hD178

`define CFG_IO_EN_BIT  5
`define CFG_TGT_RDY_BIT 4
`define CFG_ICA_EN_BIT 3
`define CFG_LSRC_BIT   2
`define CFG_SOFT_RESET_BIT_BIT   6

`define ST_PME_BIT     10
`define ST_LONG_BIT    9
`define ST_DEC_BIT     8
`define ST_FIX_BIT     7
`define ST_PERR_BIT    5
`define ST_SERR_BIT    4
`define ST_GBE_BIT     3
`define ST_BUSY_BIT    1
`define ST_DONE_BIT    0

`define STICKY_MASK    32'h0000_07B8
`define CFG_WR_MASK    32'h0000_003C

`define RST_IO_EN      1'h0
`define RST_ICA_EN     1'h1
`define RST_LSRC       1'h0

`define LOAD_CYCLES    4'h8
`define STRAP_SETTLE   2'h2

`endif

// ===== include/pci_ctrl_pkg.sv
// types shared by the pci controller config/status bank
package pci_ctrl_pkg;
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_EEP  = 2'b01,
    LOAD_REG  = 2'b10
  } load_state_t;
endpackage : pci_ctrl_pkg

// ===== rtl/pci_ctrl_cfg_status_regs.sv
// config and status registers of the pci controller with interrupt
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "pci_ctrl_cfg_status_regs.svh"

module pci_ctrl_cfg_status_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // mode straps, from pins
  input  wire logic        pci_boot_mode,
  input  wire logic        satellite_mode,
  input  wire logic        host_mode,
  // bus pins, active low
  input  wire logic        pme_n,
  input  wire logic        perr_n,
  input  wire logic        serr_n,
  // on-chip events, same clock
  input  wire logic        dma_long_burst,
  input  wire logic        dma_dec_burst,
  input  wire logic        dma_fixed_burst,
  input  wire logic        gbus_timeout,
  input  wire logic        gbus_master,
  input  wire logic        posted_write_busy,
  input  wire logic        posted_write_error,
  input  wire logic        load_seq_done,
  // target side requests
  input  wire logic        tgt_req,
  input  wire logic        tgt_cfg_req,
  output logic             tgt_accept,
  output logic             tgt_retry,
  // initiator side gating
  input  wire logic        ini_io_req,
  input  wire logic        ini_cfg_req,
  output logic             ini_io_grant,
  output logic             ini_cfg_grant,
  // load control
  output logic             load_from_regs,
  output logic             load_from_eeprom,
  output logic             write_error,
  // interrupt
  output logic             irq
);

  // pin synchronisers, two flops before use
  // only the second flop of each pair is read by logic; the third pin stage
  // exists purely to give the edge detectors a settled previous value
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [1:0] mode_s1_q;
  logic [1:0] mode_s2_q;
  logic       host_s1_q;
  logic       host_s2_q;

  // bus pins reset to their idle high level so no false edge follows reset
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 3'h7;
    end else begin
      pin_s1_q <= {pme_n, perr_n, serr_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // boot and satellite straps
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
    end else begin
      mode_s1_q <= {pci_boot_mode, satellite_mode};
      mode_s2_q <= mode_s1_q;
    end
  end

  // host mode strap, gates pme detection
  always_ff @(posedge clock) begin
    if (rst) begin
      host_s1_q <= 1'h0;
      host_s2_q <= 1'h0;
    end else begin
      host_s1_q <= host_mode;
      host_s2_q <= host_s1_q;
    end
  end

  // falling edges of the active-low pins, seen only past the second flop
  logic pme_fall;
  logic perr_fall;
  logic serr_fall;
  assign pme_fall  = pin_s3_q[2] & ~pin_s2_q[2];
  assign perr_fall = pin_s3_q[1] & ~pin_s2_q[1];
  assign serr_fall = pin_s3_q[0] & ~pin_s2_q[0];

  // decode
  logic wr_cfg;
  logic wr_st;
  logic wr_mask;
  assign wr_cfg  = wr && (addr == `OFS_CONFIG);
  assign wr_st   = wr && (addr == `OFS_STATUS);
  assign wr_mask = wr && (addr == `OFS_MASK);

  // strap capture once the synchroniser has filled after reset
  logic [1:0] strap_cnt_q;
  logic       boot_sat;
  assign boot_sat = mode_s2_q[1] & mode_s2_q[0];

  // settle counter; the straps are only trusted after two clean flops,
  // and an early config write ends the wait so software always wins
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_cnt_q <= 2'h0;
    end else if (wr_cfg) begin
      strap_cnt_q <= 2'h3;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // config register bits
  logic io_en_q;
  logic tgt_rdy_q;
  logic ica_en_q;
  logic lsrc_q;

  // plain software bits
  always_ff @(posedge clock) begin
    if (rst) begin
      io_en_q  <= `RST_IO_EN;
      ica_en_q <= `RST_ICA_EN;
      lsrc_q   <= `RST_LSRC;
    end else if (wr_cfg) begin
      io_en_q  <= wdata[`CFG_IO_EN_BIT];
      ica_en_q <= wdata[`CFG_ICA_EN_BIT];
      lsrc_q   <= wdata[`CFG_LSRC_BIT];
    end
  end

  // target ready: zero in reset, then the strap value once the straps are trusted;
  // a clear after a set is not guarded here, software must never do it
  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_rdy_q <= 1'h0;
    end else if (wr_cfg) begin
      tgt_rdy_q <= wdata[`CFG_TGT_RDY_BIT];   // software sets once
    end else if (strap_cnt_q == `STRAP_SETTLE) begin
      tgt_rdy_q <= boot_sat;
    end
  end

  // load sequencer, started by soft reset; a soft reset during a load is ignored
  pci_ctrl_pkg::load_state_t state_q;
  logic [3:0] load_cnt_q;
  logic       done_q;
  logic       soft_reset_bit;
  logic       seq_idle;
  logic       load_end;
  assign soft_reset_bit     = wr_cfg && wdata[`CFG_SOFT_RESET_BIT_BIT];
  assign seq_idle = state_q == pci_ctrl_pkg::LOAD_IDLE;
  assign load_end = (state_q == pci_ctrl_pkg::LOAD_EEP && load_seq_done)
                    || (state_q == pci_ctrl_pkg::LOAD_REG
                        && load_cnt_q == `LOAD_CYCLES - 4'h1);

  // state; leaves reset loading from the eeprom, as after power-up
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= pci_ctrl_pkg::LOAD_EEP;
    end else begin
      case (state_q)
        pci_ctrl_pkg::LOAD_IDLE: begin
          if (soft_reset_bit) begin
            // source chosen by the bit as it stood before this write
            state_q <= lsrc_q ? pci_ctrl_pkg::LOAD_REG
                              : pci_ctrl_pkg::LOAD_EEP;
          end
        end
        pci_ctrl_pkg::LOAD_EEP: begin
          if (load_end) begin
            state_q <= pci_ctrl_pkg::LOAD_IDLE;
          end
        end
        pci_ctrl_pkg::LOAD_REG: begin
          if (load_end) begin
            state_q <= pci_ctrl_pkg::LOAD_IDLE;
          end
        end
        default: begin
          state_q <= pci_ctrl_pkg::LOAD_IDLE;
        end
      endcase
    end
  end

  // register-load cycle counter, cleared whenever the sequencer is elsewhere
  always_ff @(posedge clock) begin
    if (rst) begin
      load_cnt_q <= 4'h0;
    end else if (state_q == pci_ctrl_pkg::LOAD_REG) begin
      load_cnt_q <= load_cnt_q + 4'h1;
    end else begin
      load_cnt_q <= 4'h0;
    end
  end

  // load done: cleared by a soft reset that starts a load, set when a load ends;
  // the eeprom path has no timeout, so a missing done pulse keeps it low
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'h0;
    end else if (seq_idle && soft_reset_bit) begin
      done_q <= 1'h0;
    end else if (load_end) begin
      done_q <= 1'h1;                         // set even with no eeprom
    end
  end

  // sticky event flags, set wins over write-one-clear
  logic [31:0] set_vec;
  logic [31:0] sticky_q;
  always_comb begin
    set_vec = 32'h0;
    set_vec[`ST_PME_BIT]  = pme_fall & host_s2_q;
    set_vec[`ST_LONG_BIT] = dma_long_burst;
    set_vec[`ST_DEC_BIT]  = dma_dec_burst;
    set_vec[`ST_FIX_BIT]  = dma_fixed_burst;
    set_vec[`ST_PERR_BIT] = perr_fall;
    set_vec[`ST_SERR_BIT] = serr_fall;
    set_vec[`ST_GBE_BIT]  = gbus_timeout & gbus_master;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sticky_q <= 32'h0;
    end else begin
      sticky_q <= ((sticky_q & ~(wr_st ? wdata : 32'h0)) | set_vec) & `STICKY_MASK;
    end
  end

  // interrupt mask, same layout
  logic [31:0] mask_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_q <= 32'h0;
    end else if (wr_mask) begin
      mask_q <= wdata & `STICKY_MASK;
    end
  end

  // read mux, unmapped reads give zero
  logic [31:0] cfg_view;
  logic [31:0] st_view;
  always_comb begin
    cfg_view = 32'h0;
    cfg_view[`CFG_IO_EN_BIT]   = io_en_q;
    cfg_view[`CFG_TGT_RDY_BIT] = tgt_rdy_q;
    cfg_view[`CFG_ICA_EN_BIT]  = ica_en_q;
    cfg_view[`CFG_LSRC_BIT]    = lsrc_q;
    st_view = sticky_q;
    st_view[`ST_BUSY_BIT] = posted_write_busy;
    st_view[`ST_DONE_BIT] = done_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `OFS_CONFIG: rdata <= cfg_view;
        `OFS_STATUS: rdata <= st_view;
        `OFS_MASK:   rdata <= mask_q;
        default:     rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // target answers; retry also covers plain requests that cannot be accepted yet,
  // so a plain requester never sees silence while the bank is still loading
  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_accept <= 1'h0;
      tgt_retry  <= 1'h0;
    end else begin
      tgt_accept <= tgt_req & tgt_rdy_q & done_q;
      tgt_retry  <= (tgt_cfg_req & ~tgt_rdy_q)
                    | (tgt_req & ~(tgt_rdy_q & done_q));
    end
  end

  // initiator grants, one cycle behind the request
  always_ff @(posedge clock) begin
    if (rst) begin
      ini_io_grant  <= 1'h0;
      ini_cfg_grant <= 1'h0;
    end else begin
      ini_io_grant  <= ini_io_req & io_en_q;
      ini_cfg_grant <= ini_cfg_req & ica_en_q;
    end
  end

  // load path indicators, one cycle behind the sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      load_from_regs   <= 1'h0;
      load_from_eeprom <= 1'h0;
    end else begin
      load_from_regs   <= state_q == pci_ctrl_pkg::LOAD_REG;
      load_from_eeprom <= state_q == pci_ctrl_pkg::LOAD_EEP;
    end
  end

  // write error withheld while the posted write is still busy
  always_ff @(posedge clock) begin
    if (rst) begin
      write_error <= 1'h0;
    end else begin
      write_error <= posted_write_error & ~posted_write_busy;
    end
  end

  // level interrupt; the extra flop costs a cycle but keeps the pin glitch free
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(sticky_q & mask_q);
    end
  end

endmodule : pci_ctrl_cfg_status_regs

// ===== sim/pci_ctrl_regs_properties.sv
// concurrent checks on the ports of the pci controller config/status bank
`timescale 1ns/100ps
`include "pci_ctrl_cfg_status_regs.svh"

module pci_ctrl_regs_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire logic [15:0] addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // target and initiator gating
  input wire logic        tgt_req,
  input wire logic        tgt_cfg_req,
  input wire logic        tgt_accept,
  input wire logic        tgt_retry,
  input wire logic        ini_io_req,
  input wire logic        ini_cfg_req,
  input wire logic        ini_io_grant,
  input wire logic        ini_cfg_grant,
  // load and write status
  input wire logic        load_from_regs,
  input wire logic        load_from_eeprom,
  input wire logic        posted_write_busy,
  input wire logic        posted_write_error,
  input wire logic        write_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // grants and target accepts only ever follow a request one cycle earlier, and an accept never comes with a retry
  a_io_grant_req: assert property (ini_io_grant |-> $past(ini_io_req))
    else $error("io grant without request");
  a_cfg_grant_req: assert property (ini_cfg_grant |-> $past(ini_cfg_req))
    else $error("cfg grant without request");
  a_accept_has_req: assert property (tgt_accept |-> $past(tgt_req || tgt_cfg_req))
    else $error("target accept without request");
  a_retry_not_accept: assert property (!(tgt_accept && tgt_retry))
    else $error("accept and retry together");
  // read data stand only the cycle after a read, reserved bits stay zero
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  a_status_rsvd_zero: assert property ($past(rd) && $past(addr) == `OFS_STATUS
    |-> (rdata & 32'hFFFF_F844) == 32'h0000_0000)
    else $error("status reserved bit set");
  a_config_rsvd_zero: assert property ($past(rd) && $past(addr) == `OFS_CONFIG
    |-> (rdata & 32'hFFFF_FFC3) == 32'h0000_0000)
    else $error("config reserved bit set");
  a_busy_live_bit: assert property ($past(rd) && $past(addr) == `OFS_STATUS
    |-> rdata[1] == $past(posted_write_busy))
    else $error("busy bit not live");
  // an error is withheld while the write is still busy
  a_error_after_busy: assert property (write_error == $past(posted_write_error
    && !posted_write_busy))
    else $error("write error not gated by busy");
  a_one_load_path: assert property (!(load_from_regs && load_from_eeprom))
    else $error("both load sources active");

  c_accept: cover property (tgt_accept);
  c_retry: cover property (tgt_retry);
  c_load_regs: cover property (load_from_regs);
  c_write_error: cover property (write_error);
endmodule : pci_ctrl_regs_properties

bind pci_ctrl_cfg_status_regs pci_ctrl_regs_properties pci_ctrl_regs_properties_i (.*);

// ===== sim/pci_far_side_model.sv
// far side stand-in: pci bus agents and on-chip dma event sources
`timescale 1ns/100ps

module pci_far_side_model (
  // clock and command from the bench
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [2:0] cmd,
  // pins and event lines toward the bank
  output logic            pme_n,
  output logic            perr_n,
  output logic            serr_n,
  output logic            dma_long_burst,
  output logic            dma_dec_burst,
  output logic            dma_fixed_burst,
  output logic            gbus_timeout,
  output logic            gbus_master
);
  logic [7:0] ev_q = 8'h00;

  // one clock per event; idle pins sit high, a pulse gives the synchroniser a fall
  always @(posedge clock) ev_q <= fire ? (8'h01 << cmd) : 8'h00;
  assign pme_n           = !ev_q[0];
  assign dma_long_burst  = ev_q[1];
  assign dma_dec_burst   = ev_q[2];
  assign dma_fixed_burst = ev_q[3];
  assign perr_n          = !ev_q[4];
  assign serr_n          = !ev_q[5];
  // code 7 is a timeout while another master owns the bus
  assign gbus_timeout    = ev_q[6] | ev_q[7];
  assign gbus_master     = ev_q[6];
endmodule : pci_far_side_model

// ===== sim/tb_pci_ctrl_cfg_status_regs.sv
// self-checking bench for the pci controller config/status bank
`timescale 1ns/100ps
`include "pci_ctrl_cfg_status_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end

module tb_pci_ctrl_cfg_status_regs;
  logic clock, rst = 1, wr = 0, rd = 0, rd_p = 0, fire = 0;
  logic pci_boot_mode = 0, satellite_mode = 0, host_mode = 1, load_seq_done = 0;
  logic posted_write_busy = 0, posted_write_error = 0, tgt_req = 0, tgt_cfg_req = 0;
  logic ini_io_req = 0, ini_cfg_req = 0, tgt_accept, tgt_retry, ini_io_grant, ini_cfg_grant;
  logic load_from_regs, load_from_eeprom, write_error, irq;
  logic pme_n, perr_n, serr_n, dma_long_burst, dma_dec_burst, dma_fixed_burst;
  logic gbus_timeout, gbus_master;
  logic [2:0]  cmd = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata, e, m, seed = 32'h0000_B378;
  logic [31:0] exp_q[$], msk_q[$];
  logic [31:0] ev_bit [8] = '{32'h400, 32'h200, 32'h100, 32'h80, 32'h20, 32'h10, 32'h8, 32'h0};
  int n_errors = 0, check_count = 0;

  pci_ctrl_cfg_status_regs pci_ctrl_cfg_status_regs_i (.*);
  pci_far_side_model pci_far_side_model_i (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // settle a little past the edge so sampled outputs are final
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // the note is queued with the strobe; the watcher matches it a cycle later
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] ex, input logic [31:0] mk);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(ex & mk);
    msk_q.push_back(mk);
    @(posedge clock);
    rd <= 1'b0;
    tick(1);
  endtask : rd_reg

  task automatic fire_ev(input logic [2:0] c);
    @(posedge clock);
    fire <= 1'b1;
    cmd <= c;
    @(posedge clock);
    fire <= 1'b0;
  endtask : fire_ev

  // bounded wait for a load path; running out ends the run
  task automatic wait_load(input logic regs);
    int k;
    for (k = 0; k < 50 && (regs ? load_from_regs : load_from_eeprom) !== 1'b1; k++) tick(1);
    `CHK("load_path", 1'b1, regs ? load_from_regs : load_from_eeprom)
    if (k == 50) stop_test();
  endtask : wait_load

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // read watcher
  always @(posedge clock) begin
    if (rd_p) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata & m)
    end
    rd_p <= rd;
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    tick(4);
    rd_reg(`OFS_CONFIG, 32'h8, 32'hFFFF_FFFF);
    rd_reg(`OFS_STATUS, 32'h0, 32'hFFFF_FFFF);
    rd_reg(16'hD17C, 32'h0, 32'hFFFF_FFFF);
    wr_reg(`OFS_CONFIG, 32'hFFFF_FF83);
    rd_reg(`OFS_CONFIG, 32'h0, 32'hFFFF_FFFF);
    ini_io_req <= 1'b1;
    ini_cfg_req <= 1'b1;
    tick(2);
    `CHK("io_grant", 1'b0, ini_io_grant)
    `CHK("cfg_grant", 1'b0, ini_cfg_grant)
    wr_reg(`OFS_CONFIG, 32'h28);
    tick(2);
    `CHK("io_grant", 1'b1, ini_io_grant)
    `CHK("cfg_grant", 1'b1, ini_cfg_grant)
    // target side: retry until ready and loaded
    tgt_cfg_req <= 1'b1;
    tgt_req <= 1'b1;
    load_seq_done <= 1'b1;
    tick(2);
    load_seq_done <= 1'b0;
    `CHK("retry", 1'b1, tgt_retry)
    `CHK("accept", 1'b0, tgt_accept)
    rd_reg(`OFS_STATUS, 32'h1, 32'h1);
    wr_reg(`OFS_CONFIG, 32'h38);
    tick(3);
    `CHK("accept", 1'b1, tgt_accept)
    tgt_cfg_req <= 1'b0;
    tgt_req <= 1'b0;
    // every event code, with interrupt raise and clear; code 7 must set no flag and no interrupt
    wr_reg(`OFS_MASK, 32'h7B8);
    for (int i = 0; i < 8; i++) begin
      fire_ev(3'(i));
      tick(8);
      rd_reg(`OFS_STATUS, ev_bit[i], 32'h7B8);
      `CHK("irq", |ev_bit[i], irq)
      wr_reg(`OFS_STATUS, ev_bit[i]);
      tick(3);
      `CHK("irq", 1'b0, irq)
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr_reg(`OFS_MASK, seed);
      rd_reg(`OFS_MASK, seed & `STICKY_MASK, 32'hFFFF_FFFF);
    end
    // masked event: flag sticks, no interrupt
    wr_reg(`OFS_MASK, 32'h0);
    fire_ev(3'h1);
    tick(4);
    `CHK("irq", 1'b0, irq)
    rd_reg(`OFS_STATUS, 32'h200, 32'h7B8);
    wr_reg(`OFS_STATUS, 32'hFFFF_FFFF);
    rd_reg(`OFS_STATUS, 32'h0, 32'h7B8);
    // posted write: busy shown live, error held back until it drops
    posted_write_busy <= 1'b1;
    posted_write_error <= 1'b1;
    tick(2);
    rd_reg(`OFS_STATUS, 32'h2, 32'h2);
    `CHK("write_error", 1'b0, write_error)
    posted_write_busy <= 1'b0;
    tick(2);
    `CHK("write_error", 1'b1, write_error)
    posted_write_error <= 1'b0;
    // soft reset from registers, then from the eeprom path; source bit set beforehand
    wr_reg(`OFS_CONFIG, 32'h3C);
    wr_reg(`OFS_CONFIG, 32'h7C);
    wait_load(1'b1);
    tick(12);
    rd_reg(`OFS_STATUS, 32'h1, 32'h1);
    wr_reg(`OFS_CONFIG, 32'h38);
    wr_reg(`OFS_CONFIG, 32'h78);
    wait_load(1'b0);
    rd_reg(`OFS_STATUS, 32'h0, 32'h1);
    load_seq_done <= 1'b1;
    tick(1);
    load_seq_done <= 1'b0;
    tick(3);
    rd_reg(`OFS_STATUS, 32'h1, 32'h1);
    // second reset in boot and satellite mode
    pci_boot_mode <= 1'b1;
    satellite_mode <= 1'b1;
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(6);
    rd_reg(`OFS_CONFIG, 32'h18, 32'hFFFF_FFFF);
    tick(3);
    stop_test();
  end
endmodule : tb_pci_ctrl_cfg_status_regs
